// ### design/swc_pkg.sv
// Constants, register map and types for the sleep and wake-up controller.
// Assumes a 50 MHz core_clk and a 32-bit Avalon-MM slave port.
package swc_pkg;
   // Register byte offsets
   localparam logic [4:0] SWC_CTRL_OFS = 5'h00;
   localparam logic [4:0] SWC_STAT_OFS = 5'h04;
   localparam logic [4:0] SWC_IEN_OFS = 5'h08;
   localparam logic [4:0] SWC_IFLG_OFS = 5'h0c;
   localparam logic [4:0] SWC_WDTP_OFS = 5'h10;
   localparam logic [4:0] SWC_PC_OFS = 5'h14;
   // Control register fields
   localparam int SWC_CTRL_WDTEN = 0;
   localparam int SWC_CTRL_MODE = 1;
   localparam int SWC_CTRL_PSA = 3;
   localparam int SWC_CTRL_PS = 4;
   // Interrupt enable and flag fields
   localparam int SWC_INT_EXT = 0;
   localparam int SWC_INT_PIN = 1;
   localparam int SWC_INT_EE = 2;
   localparam int SWC_IEN_GIE = 3;
   // Reset values and interrupt vector
   localparam logic [6:0] SWC_CTRL_RST = 7'h00;
   localparam logic [3:0] SWC_IEN_RST = 4'h0;
   localparam logic [15:0] SWC_WDTP_RST = 16'h0100;
   localparam logic [12:0] SWC_PC_RST = 13'h0000;
   localparam logic [12:0] SWC_VECTOR = 13'h0004;
   // Oscillator start-up wait, in oscillator cycles
   localparam logic [10:0] SWC_OST_CYCLES = 11'd1024;
   // Clock output divides the oscillator by this figure
   localparam int SWC_CLKOUT_DIV = 4;
   localparam logic [0:0] SWC_CLKOUT_HALF = 1'(SWC_CLKOUT_DIV / 2 - 1);
   typedef enum logic [1:0] {
      SWC_MODE_RC,
      SWC_MODE_LP,
      SWC_MODE_XT,
      SWC_MODE_HS
   } swc_mode_e;
   typedef enum {
      SWC_AWAKE,
      SWC_SLEEP,
      SWC_OST_WAIT,
      SWC_RESUME
   } swc_state_e;
endpackage

// ### design/swc_sleep_wakeup_control.sv
// Sleep entry and wake-up control for a small 8-bit core, with a register port.
// Assumes the core pulses sleep_exec for one cycle with its current program address,
// and that event inputs other than pins come from logic on core_clk.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Sleep instruction enters power-down mode
// - Sleep clears watchdog, watchdog keeps running
// - Sleep clears power-down, sets timeout, stops clock
// - I/O pins hold their state in sleep
// - Watchdog reset never pulls master-clear low
// - Wake on master-clear, watchdog, enabled interrupts
// - Master-clear resets; watchdog, interrupt wake resumes
// - Power-down flag set at power-up, cleared by sleep
// - Watchdog wake clears timeout flag
// - Sleep prefetches instruction at next address
// - Interrupt wakes only if individually enabled
// - Interrupt wake ignores global enable
// - Global disabled: resume in line
// - Global enabled: prefetched instruction, then vector
// - Pending enabled flag wakes at once
// - Every wake-up clears the watchdog
// - Resistor-capacitor mode drives clock divided by four
// - Crystal modes wait 1024 cycles after wake, except on master-clear wake
// - Sleep clears prescaler when assigned to watchdog
module swc_sleep_wakeup_control (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic sleep_exec,
   input wire logic clear_watchdog_exec,
   input wire logic [12:0] core_pc,
   output logic core_run,
   output logic core_reset,
   output logic resume,
   output logic vector_req,
   output logic [12:0] vector_addr,
   output logic [12:0] prefetch_addr,
   output logic io_hold,
   input wire logic master_clear_pin_in,
   output logic master_clear_pin_out,
   output logic master_clear_pin_oe,
   input wire logic watchdog_osc_pin,
   input wire logic ext_int_pin,
   input wire logic pin_change_interrupt,
   input wire logic eeprom_write_done,
   output logic clock_output_pin
);
   import swc_pkg::*;

   swc_state_e state;
   logic [6:0] ctrl;
   logic [3:0] int_enable;
   logic [2:0] int_flag;
   logic [15:0] watchdog_period;
   logic [15:0] watchdog_timer;
   logic [7:0] prescaler;
   logic power_down_flag;
   logic timeout_flag;
   logic [10:0] ost_cnt;
   logic [0:0] clk_div;
   logic gie_at_wake;
   logic ack;
   logic [1:0] master_clear_pin_sync;
   logic [2:0] wdt_sync;
   logic [2:0] ext_sync;

   // Pins cross into core_clk through two flops before any logic looks at them
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         master_clear_pin_sync <= 2'b11;
         wdt_sync <= 3'b000;
         ext_sync <= 3'b000;
      end else begin
         master_clear_pin_sync <= {master_clear_pin_sync[0], master_clear_pin_in};
         wdt_sync <= {wdt_sync[1:0], watchdog_osc_pin};
         ext_sync <= {ext_sync[1:0], ext_int_pin};
      end
   end

   logic master_clear_pin_low;
   logic wdt_edge;
   logic ext_edge;
   logic wdt_en;
   logic xtal_mode;
   logic pre_to_wdt;
   logic [7:0] pre_mask;
   logic wdt_tick;
   logic wdt_fire;
   logic enter_sleep;
   logic int_pending;
   logic wake_soft;
   logic [2:0] int_set;
   logic bus_wr;
   logic bus_rd;

   assign master_clear_pin_low = !master_clear_pin_sync[1];
   assign wdt_edge = wdt_sync[1] && !wdt_sync[2];
   assign ext_edge = ext_sync[1] && !ext_sync[2];
   assign wdt_en = ctrl[SWC_CTRL_WDTEN];
   assign xtal_mode = swc_mode_e'(ctrl[SWC_CTRL_MODE +: 2]) != SWC_MODE_RC;
   assign pre_to_wdt = ctrl[SWC_CTRL_PSA];
   assign pre_mask = 8'((9'h001 << ctrl[SWC_CTRL_PS +: 3]) - 9'h001);
   assign wdt_tick = wdt_edge && (!pre_to_wdt || ((prescaler & pre_mask) == pre_mask));
   assign wdt_fire = wdt_en && wdt_tick && (watchdog_timer >= watchdog_period);
   assign enter_sleep = sleep_exec && state == SWC_AWAKE && !master_clear_pin_low;
   assign int_set = {eeprom_write_done, pin_change_interrupt, ext_edge};
   // each source gated by its own enable
   // global enable plays no part here
   assign int_pending = |(int_flag & int_enable[2:0]);
   assign wake_soft = wdt_fire || int_pending;
   // Write commits at the edge where the master sees waitrequest low
   assign bus_wr = avs_write && ack;
   assign bus_rd = avs_read && !ack;

   // One wait cycle on every access keeps read data registered
   assign avs_waitrequest = (avs_read || avs_write) && !ack;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read || avs_write) && !ack;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (bus_rd) begin
         if (avs_address == SWC_CTRL_OFS) begin
            avs_readdata <= {25'h0, ctrl};
         end else if (avs_address == SWC_STAT_OFS) begin
            avs_readdata <= {28'h0, state == SWC_OST_WAIT, state == SWC_SLEEP,
                             timeout_flag, power_down_flag};
         end else if (avs_address == SWC_IEN_OFS) begin
            avs_readdata <= {28'h0, int_enable};
         end else if (avs_address == SWC_IFLG_OFS) begin
            avs_readdata <= {29'h0, int_flag};
         end else if (avs_address == SWC_WDTP_OFS) begin
            avs_readdata <= {16'h0, watchdog_period};
         end else if (avs_address == SWC_PC_OFS) begin
            avs_readdata <= {19'h0, prefetch_addr};
         end else begin
            avs_readdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= SWC_CTRL_RST;
         int_enable <= SWC_IEN_RST;
         watchdog_period <= SWC_WDTP_RST;
      end else if (bus_wr) begin
         if (avs_address == SWC_CTRL_OFS && avs_byteenable[0]) begin
            ctrl <= avs_writedata[6:0];
         end else if (avs_address == SWC_IEN_OFS && avs_byteenable[0]) begin
            int_enable <= avs_writedata[3:0];
         end else if (avs_address == SWC_WDTP_OFS) begin
            if (avs_byteenable[0]) begin
               watchdog_period[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
               watchdog_period[15:8] <= avs_writedata[15:8];
            end
         end
      end
   end

   // Write one to clear; a new event in the same cycle keeps its flag
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_flag <= 3'b000;
      end else if (bus_wr && avs_address == SWC_IFLG_OFS && avs_byteenable[0]) begin
         int_flag <= (int_flag & ~avs_writedata[2:0]) | int_set;
      end else begin
         int_flag <= int_flag | int_set;
      end
   end

   // Watchdog runs from its own oscillator edges, so it keeps counting in sleep
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdog_timer <= 16'h0000;
         prescaler <= 8'h00;
      end else if (enter_sleep || clear_watchdog_exec || master_clear_pin_low) begin
         watchdog_timer <= 16'h0000;
         // prescaler cleared only when it serves the watchdog
         if (pre_to_wdt) begin
            prescaler <= 8'h00;
         end
      end else if (wdt_fire || (state == SWC_SLEEP && int_pending)) begin
         watchdog_timer <= 16'h0000;
      end else begin
         if (wdt_edge && pre_to_wdt) begin
            prescaler <= prescaler + 8'h01;
         end
         if (wdt_tick && wdt_en) begin
            watchdog_timer <= watchdog_timer + 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_down_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end else if (enter_sleep) begin
         power_down_flag <= 1'b0;
         timeout_flag <= 1'b1;
      end else if (wdt_fire) begin
         timeout_flag <= 1'b0;
         if (state != SWC_SLEEP) begin
            power_down_flag <= 1'b1;
         end
      end else if (master_clear_pin_low && state == SWC_SLEEP) begin
         timeout_flag <= 1'b1;
      end
   end

   // next address latched as sleep executes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prefetch_addr <= SWC_PC_RST;
      end else if (enter_sleep) begin
         prefetch_addr <= core_pc + 13'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SWC_AWAKE;
         ost_cnt <= 11'h000;
         gie_at_wake <= 1'b0;
      end else if (master_clear_pin_low) begin
         // master clear returns to awake from any state; registers keep their values
         state <= SWC_AWAKE;
         ost_cnt <= 11'h000;
      end else begin
         case (state)
            SWC_AWAKE: begin
               if (enter_sleep) begin
                  state <= SWC_SLEEP;
               end
            end
            SWC_SLEEP: begin
               // a flag already pending wakes on the first sleep cycle
               if (wake_soft) begin
                  gie_at_wake <= int_enable[SWC_IEN_GIE] && !wdt_fire;
                  ost_cnt <= 11'h000;
                  // crystal modes wait for the oscillator
                  state <= xtal_mode ? SWC_OST_WAIT : SWC_RESUME;
               end
            end
            SWC_OST_WAIT: begin
               ost_cnt <= ost_cnt + 11'h001;
               if (ost_cnt == SWC_OST_CYCLES - 11'h001) begin
                  state <= SWC_RESUME;
               end
            end
            SWC_RESUME: begin
               state <= SWC_AWAKE;
            end
            default: begin
               state <= SWC_AWAKE;
            end
         endcase
      end
   end

   // core stopped and its program address frozen while not awake
   assign core_run = state == SWC_AWAKE && !master_clear_pin_low;
   // outputs frozen until the state returns to awake
   assign io_hold = state != SWC_AWAKE;
   // pin is never driven, watchdog reset stays internal
   assign master_clear_pin_out = 1'b0;
   assign master_clear_pin_oe = 1'b0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_reset <= 1'b1;
         resume <= 1'b0;
         vector_req <= 1'b0;
         vector_addr <= SWC_PC_RST;
      end else begin
         // master clear or waking-awake watchdog resets, sleep wakes resume
         core_reset <= master_clear_pin_low || (wdt_fire && state == SWC_AWAKE);
         resume <= state == SWC_RESUME;
         // no vector with global interrupts off
         vector_req <= state == SWC_RESUME && gie_at_wake;
         vector_addr <= SWC_VECTOR;
      end
   end

   // divide by four, only while the oscillator runs in RC mode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_div <= 1'b0;
         clock_output_pin <= 1'b0;
      end else if (!xtal_mode && core_run) begin
         clk_div <= clk_div + 1'b1;
         if (clk_div == SWC_CLKOUT_HALF) begin
            clock_output_pin <= !clock_output_pin;
         end
      end else begin
         clk_div <= 1'b0;
         clock_output_pin <= 1'b0;
      end
   end

   a_sleep_stops_core: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      enter_sleep |=> !core_run && io_hold && state == SWC_SLEEP)
      else $error("sleep did not stop the core");

   a_sleep_status_flags: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      enter_sleep |=> !power_down_flag && timeout_flag)
      else $error("sleep entry flags wrong");

   a_sleep_clear_wdt: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      enter_sleep |=> watchdog_timer == 16'h0000)
      else $error("watchdog not cleared on sleep");

   a_prefetch_next: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      enter_sleep |=> prefetch_addr == $past(core_pc) + 13'h0001)
      else $error("prefetch address not pc plus one");

   a_master_clear_pin_not_driven: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      wdt_fire |-> ##[0:2] !master_clear_pin_oe)
      else $error("master clear pin driven");

   a_wdt_wake_flag: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state == SWC_SLEEP && wdt_fire && !master_clear_pin_low) |=> !timeout_flag && state != SWC_SLEEP)
      else $error("watchdog wake did not clear timeout flag");

   a_xtal_ost_wait: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state == SWC_SLEEP && wake_soft && xtal_mode && !master_clear_pin_low)
      |=> (!core_run && !master_clear_pin_low) [*8] ##1 !resume)
      else $error("crystal wake did not wait");

   a_rc_no_wait: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state == SWC_SLEEP && wake_soft && !xtal_mode && !master_clear_pin_low) ##1 !master_clear_pin_low
      |=> resume)
      else $error("rc wake was delayed");

   a_vector_gie: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      resume |-> vector_req == gie_at_wake && vector_addr == SWC_VECTOR)
      else $error("vector request disagrees with global enable");

   a_no_enable_stays: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state == SWC_SLEEP && !int_pending && !wdt_fire && !master_clear_pin_low) |=> state == SWC_SLEEP)
      else $error("woke without an enabled source");

   a_wake_clears_wdt: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state == SWC_SLEEP && wake_soft) |=> watchdog_timer == 16'h0000)
      else $error("wake did not clear watchdog");

   a_clkout_period: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      ($rose(clock_output_pin) && !xtal_mode && core_run) ##1 (!xtal_mode && core_run) [*3]
      |=> $rose(clock_output_pin) && !$past(clock_output_pin, 2))
      else $error("clock output not divided by four");
endmodule

`default_nettype wire

// ### tb/swc_partner.sv
// Far-side model: master-clear driver, interrupt sources and watchdog RC clock.
// Assumes the bench requests events by pulses on core_clk.
`timescale 1ns/10ps
`default_nettype none
module swc_partner (
   input wire logic core_clk,
   input wire logic master_clear_pin_assert,
   input wire logic [2:0] irq_go,
   output logic master_clear_pin_in,
   output logic ext_int_pin,
   output logic pin_change_interrupt,
   output logic eeprom_write_done,
   output logic watchdog_osc_pin
);
   logic [1:0] osc_div = 2'h0;
   logic [2:0] ext_len = 3'h0;
   logic osc_q = 1'b0;
   logic pin_q = 1'b0;
   logic ee_q = 1'b0;
   assign watchdog_osc_pin = osc_q;
   assign pin_change_interrupt = pin_q;
   assign eeprom_write_done = ee_q;
   // held high unless reset
   // Pull-up on the pin, so a released pin reads high
   assign master_clear_pin_in = !master_clear_pin_assert;
   // Stretched so the two-stage synchroniser cannot miss it
   assign ext_int_pin = (ext_len != 3'h0);
   // The RC clock runs free, also while the core sleeps
   always @(posedge core_clk) begin
      osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
      if (osc_div == 2'h2) osc_q <= !osc_q;
      ext_len <= irq_go[0] ? 3'h4 : (ext_len != 3'h0 ? ext_len - 3'h1 : 3'h0);
      pin_q <= irq_go[1];
      ee_q <= irq_go[2];
   end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the sleep and wake-up controller.
// Assumes the partner model drives the pins; the bench drives bus and core port.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import swc_pkg::*;
   logic core_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
   logic [4:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, rd;
   logic [3:0] avs_byteenable = 4'hf;
   logic sleep_exec = 0, clear_watchdog_exec = 0, master_clear_pin_assert = 0;
   logic [2:0] irq_go = 0;
   logic [12:0] core_pc = 0, vector_addr, prefetch_addr;
   logic avs_waitrequest, core_run, core_reset, resume, vector_req, io_hold;
   logic master_clear_pin_in, master_clear_pin_out, master_clear_pin_oe;
   logic watchdog_osc_pin, ext_int_pin, pin_change_interrupt, eeprom_write_done;
   logic clock_output_pin;
   int errors = 0, n_checks = 0;
   swc_sleep_wakeup_control u_dut (.core_clk, .rst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .sleep_exec, .clear_watchdog_exec, .core_pc, .core_run, .core_reset, .resume,
      .vector_req, .vector_addr, .prefetch_addr, .io_hold, .master_clear_pin_in,
      .master_clear_pin_out, .master_clear_pin_oe, .watchdog_osc_pin, .ext_int_pin,
      .pin_change_interrupt, .eeprom_write_done, .clock_output_pin);
   swc_partner u_partner (.core_clk, .master_clear_pin_assert, .irq_go, .master_clear_pin_in,
      .ext_int_pin, .pin_change_interrupt, .eeprom_write_done, .watchdog_osc_pin);
   always #10 core_clk = ~core_clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
   endtask
   task automatic go_sleep(input logic [12:0] pc);
      @(posedge core_clk);
      sleep_exec <= 1;
      core_pc <= pc;
      @(posedge core_clk);
      sleep_exec <= 0;
   endtask
   task automatic raise(input logic [2:0] m);
      @(posedge core_clk);
      irq_go <= m;
      @(posedge core_clk);
      irq_go <= 0;
   endtask
   // Counts cycles up to the resume pulse and notes whether it vectors
   task automatic wait_wake(output int n, output logic v);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (resume !== 1'b1 && n < 1200);
      v = vector_req;
   endtask
   task automatic clk_rises(output int r);
      logic p;
      r = 0;
      @(negedge core_clk);
      p = clock_output_pin;
      repeat (40) begin
         @(negedge core_clk);
         if (clock_output_pin === 1'b1 && p === 1'b0) r++;
         p = clock_output_pin;
      end
   endtask
   task automatic s_reset;
      chk(vector_addr, SWC_VECTOR);
      bus(0, SWC_STAT_OFS, 0);
      chk(rd[3:0], 4'h3);
      bus(1, 5'h18, 32'h5a);
      bus(0, 5'h18, 0);
      chk(rd, 32'h0);
      chk(master_clear_pin_oe, 0);
   endtask
   task automatic s_int_plain;
      int n;
      logic v;
      bus(1, SWC_IEN_OFS, 32'h1);
      go_sleep(13'h0123);
      @(negedge core_clk);
      chk(core_run, 0);
      chk(io_hold, 1);
      bus(0, SWC_STAT_OFS, 0);
      chk(rd[2:0], 3'h6);
      bus(0, SWC_PC_OFS, 0);
      chk(rd[12:0], 13'h0124);
      raise(3'b010);
      repeat (30) @(negedge core_clk);
      chk(io_hold, 1);
      chk(core_run, 0);
      raise(3'b001);
      wait_wake(n, v);
      chk(n < 12, 1);
      chk(v, 0);
      chk(core_reset, 0);
      bus(1, SWC_IFLG_OFS, 32'h7);
   endtask
   task automatic s_gie;
      int n;
      logic v;
      bus(1, SWC_IEN_OFS, 32'ha);
      go_sleep(13'h0ffe);
      raise(3'b010);
      wait_wake(n, v);
      chk(n < 12, 1);
      chk(v, 1);
      chk(prefetch_addr, 13'h0fff);
      bus(1, SWC_IFLG_OFS, 32'h7);
   endtask
   task automatic s_pending;
      int n;
      logic v;
      bus(1, SWC_IEN_OFS, 32'h4);
      raise(3'b100);
      go_sleep(13'h0200);
      wait_wake(n, v);
      chk(n < 6, 1);
      bus(1, SWC_IFLG_OFS, 32'h7);
   endtask
   task automatic s_osc;
      int n, r;
      logic v;
      bus(1, SWC_CTRL_OFS, 32'h0);
      clk_rises(r);
      chk(r, 10);
      bus(1, SWC_IEN_OFS, 32'h1);
      for (int m = 1; m < 4; m++) begin
         bus(1, SWC_CTRL_OFS, 32'(m << SWC_CTRL_MODE));
         clk_rises(r);
         chk(r, 0);
         go_sleep(13'h0300);
         raise(3'b001);
         wait_wake(n, v);
         chk(n >= 1026 && n < 1045, 1);
         bus(1, SWC_IFLG_OFS, 32'h7);
      end
   endtask
   task automatic s_wdt;
      int n;
      logic v;
      bus(1, SWC_IEN_OFS, 32'h8);
      bus(1, SWC_WDTP_OFS, 32'h8);
      bus(1, SWC_CTRL_OFS, 32'h9);
      @(posedge core_clk);
      clear_watchdog_exec <= 1;
      @(posedge core_clk);
      clear_watchdog_exec <= 0;
      go_sleep(13'h0400);
      wait_wake(n, v);
      chk(n >= 40 && n < 120, 1);
      chk(v, 0);
      bus(1, SWC_CTRL_OFS, 32'h0);
      chk(core_reset, 0);
      chk(master_clear_pin_oe, 0);
      bus(0, SWC_STAT_OFS, 0);
      chk(rd[1:0], 2'h0);
   endtask
   task automatic s_master_clear_pin;
      int n;
      bus(1, SWC_IEN_OFS, 32'h1);
      go_sleep(13'h0040);
      @(posedge core_clk);
      master_clear_pin_assert <= 1;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (core_reset !== 1'b1 && n < 10);
      chk(core_reset, 1);
      chk(master_clear_pin_oe, 0);
      chk(master_clear_pin_out, 0);
      repeat (5) @(posedge core_clk);
      master_clear_pin_assert <= 0;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (core_reset !== 1'b0 && n < 10);
      chk(core_run, 1);
      bus(0, SWC_STAT_OFS, 0);
      chk(rd[1:0], 2'h2);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1;
      repeat (2) @(negedge core_clk);
      s_reset();
      s_int_plain();
      s_gie();
      s_pending();
      s_osc();
      s_wdt();
      s_master_clear_pin();
      summarize();
   end
   initial begin
      #200000;
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
